// >>> logic/smtseq_top.v
// Purpose: scan and measure layers of a trigger sequencer
// Assumes: inputs synchronous, event inputs one-cycle pulses
// Notes: link lines are open drain, oe high pulls low
`timescale 1ns/1ps
`include "smtseq_defs.vh"
module smtseq_top
#(
   parameter MS_CYCLES = `SMT_CLK_HZ / 1000 * `SMT_TICK_MS
)
(
   input wire clk_in,
   input wire rst_in,
   input wire [3:0] addr_in,
   input wire [31:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rdata_out,
   input wire bus_trig_in,
   input wire ext_trig_in,
   input wire link_trig_in,
   input wire trig_key_in,
   input wire remote_in,
   input wire action_done_in,
   output reg chan_open_out,
   output reg chan_close_out,
   output reg meas_start_out,
   output reg done_pulse_out,
   output reg [5:0] link_oe_out,
   output reg [5:0] link_o_out,
   output reg armed_out
);
   // output pulse length in cycles
   localparam PULSE_CYC = `SMT_PULSE_NS * (`SMT_CLK_HZ / 1000000) / 1000;
   // sequencer states
   localparam ST_IDLE = 4'h0;
   localparam ST_SSRC = 4'h1;
   localparam ST_SDLY = 4'h2;
   localparam ST_MSRC = 4'h3;
   localparam ST_MDLY = 4'h4;
   localparam ST_AOPN = 4'h5;
   localparam ST_ACLS = 4'h6;
   localparam ST_ASET = 4'h7;
   localparam ST_AMEA = 4'h8;
   localparam ST_MOUT = 4'h9;

   // configuration
   reg [2:0] scan_event_select;
   reg [2:0] meas_src;
   reg skip_direction_select; // one enables first-pass skip
   reg semi_sync; // link mode
   reg [2:0] link_line;
   reg [29:0] scan_tmr;
   reg [29:0] scan_wait_time;
   reg [29:0] meas_tmr;
   reg [29:0] meas_wait;
   reg [16:0] scan_repeat_count; // zero is infinite
   reg [16:0] meas_cnt; // zero is infinite
   // sequencer state
   reg [3:0] state;
   reg [3:0] next_state;
   reg [16:0] scan_done_n; // scans finished
   reg [16:0] meas_done_n; // measures finished
   reg scan_first; // first scan-layer pass
   reg meas_first; // first measure-layer pass
   reg ignored; // sticky trigger-ignored
   // pending skip commands
   reg scan_imm_p;
   reg scan_sig_p;
   reg meas_imm_p;
   reg meas_sig_p;
   // millisecond prescaler
   reg [15:0] pre;
   reg ms_tick;
   // output pulse timer
   reg [9:0] pulse_left;
   reg pulse_link; // pulse goes to link line
   // timer handshakes
   wire stmr_done;
   wire mtmr_done;
   wire dly_done;
   reg stmr_go;
   reg mtmr_go;
   reg dly_go;
   reg [29:0] dly_val;

   // write decode
   wire wr_ctrl = wr_in && (addr_in == `SMT_REG_CTRL);
   wire cmd_start = wr_ctrl && wdata_in[`SMT_CTL_START];
   wire cmd_abort = wr_ctrl && wdata_in[`SMT_CTL_ABORT];
   wire cmd_grst = wr_ctrl && wdata_in[`SMT_CTL_GRST];
   wire cmd_prst = wr_ctrl && wdata_in[`SMT_CTL_PRST];

   // one layer's source satisfied this cycle
   function src_hit;
      input [2:0] src;
      input tmr_ok;
      input first;
      input fps;
      input bus_t;
      input ext_t;
      input link_t;
      input key_t;
      input rem;
      begin
         case (src)
            `SMT_SRC_IMM: src_hit = 1'b1;
            `SMT_SRC_TMR: src_hit = first | tmr_ok;
            `SMT_SRC_MAN: src_hit = key_t & ~rem;
            `SMT_SRC_BUS: src_hit = bus_t;
            `SMT_SRC_EXT: src_hit = ext_t | (fps & first);
            `SMT_SRC_LINK: src_hit = link_t | (fps & first);
            default: src_hit = 1'b0;
         endcase
      end
   endfunction

   // count still has passes left after one more
   function more;
      input [16:0] limit;
      input [16:0] done_n;
      begin
         more = (limit == `SMT_CNT_INF) || (done_n + 17'h00001 < limit);
      end
   endfunction

   wire scan_ev = src_hit(scan_event_select, stmr_done, scan_first,
      skip_direction_select, bus_trig_in, ext_trig_in, link_trig_in,
      trig_key_in, remote_in);
   wire meas_ev = src_hit(meas_src, mtmr_done, meas_first,
      skip_direction_select, bus_trig_in, ext_trig_in, link_trig_in,
      trig_key_in, remote_in);
   // layer whose source is now in charge
   wire in_scan = (state == ST_SSRC) || (state == ST_SDLY);
   wire [2:0] act_src = in_scan ? scan_event_select : meas_src;

   // delay and interval timers
   smtseq_timer u_stmr
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(stmr_go),
      .tick_in(ms_tick),
      .value_in(scan_tmr),
      .done_out(stmr_done)
   );
   smtseq_timer u_mtmr
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(mtmr_go),
      .tick_in(ms_tick),
      .value_in(meas_tmr),
      .done_out(mtmr_done)
   );
   smtseq_timer u_dly
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(dly_go),
      .tick_in(ms_tick),
      .value_in(dly_val),
      .done_out(dly_done)
   );

   // millisecond tick
   always @(posedge clk_in)
   begin
      if (rst_in || pre == MS_CYCLES[15:0] - 16'h0001)
         pre <= 16'h0000;
      else
         pre <= pre + 16'h0001;
      ms_tick <= !rst_in && (pre == MS_CYCLES[15:0] - 16'h0001);
   end

   // configuration writes and presets
   always @(posedge clk_in)
   begin
      if (rst_in || cmd_grst || cmd_prst)
      begin
         scan_event_select <= `SMT_SRC_IMM;
         scan_wait_time <= `SMT_TIME_RST;
         meas_src <= `SMT_SRC_IMM;
         meas_wait <= `SMT_TIME_RST;
         scan_repeat_count <= cmd_prst && !rst_in ? `SMT_CNT_INF : `SMT_CNT_ONE;
         meas_cnt <= `SMT_CNT_ONE;
         skip_direction_select <= 1'b0;
         semi_sync <= 1'b0;
         link_line <= 3'h0;
         scan_tmr <= `SMT_TMR_RST;
         meas_tmr <= `SMT_TMR_RST;
      end
      else if (wr_in)
      begin
         case (addr_in)
            `SMT_REG_CFG:
            begin
               scan_event_select <= wdata_in[`SMT_CFG_SSRC_LSB +: 3];
               meas_src <= wdata_in[`SMT_CFG_MSRC_LSB +: 3];
               skip_direction_select <= wdata_in[`SMT_CFG_FPS];
               semi_sync <= wdata_in[`SMT_CFG_SEMI];
               link_line <= wdata_in[`SMT_CFG_LINE_LSB +: 3];
            end
            `SMT_REG_STMR: scan_tmr <= wdata_in[29:0];
            `SMT_REG_SDLY: scan_wait_time <= wdata_in[29:0];
            `SMT_REG_MTMR: meas_tmr <= wdata_in[29:0];
            `SMT_REG_MDLY: meas_wait <= wdata_in[29:0];
            `SMT_REG_SCNT: scan_repeat_count <= wdata_in[16:0];
            `SMT_REG_MCNT: meas_cnt <= wdata_in[16:0];
            default: ;
         endcase
      end
   end

   // next state
   always @*
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (cmd_start)
               next_state = ST_SSRC;
         ST_SSRC:
            if (scan_imm_p)
               next_state = ST_MSRC;
            else if (scan_sig_p || scan_ev)
               next_state = ST_SDLY;
         ST_SDLY:
            if (dly_done && !dly_go)
               next_state = ST_MSRC;
         ST_MSRC:
            if (meas_imm_p)
               next_state = ST_AOPN;
            else if (meas_sig_p || meas_ev)
               next_state = ST_MDLY;
         ST_MDLY:
            if (dly_done && !dly_go)
               next_state = ST_AOPN;
         ST_AOPN: next_state = ST_ACLS;
         ST_ACLS: next_state = ST_ASET;
         ST_ASET:
            if (dly_done && !dly_go)
               next_state = ST_AMEA;
         ST_AMEA:
            if (action_done_in && !meas_start_out)
               next_state = ST_MOUT;
         ST_MOUT:
            if (more(meas_cnt, meas_done_n))
               next_state = ST_MSRC;
            else if (more(scan_repeat_count, scan_done_n))
               next_state = ST_SSRC;
            else
               next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
      if (cmd_abort)
         next_state = ST_IDLE;
   end

   // sequencer registers
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state <= ST_IDLE;
         scan_done_n <= 17'h00000;
         meas_done_n <= 17'h00000;
         scan_first <= 1'b1;
         meas_first <= 1'b1;
         stmr_go <= 1'b0;
         mtmr_go <= 1'b0;
         dly_go <= 1'b0;
         dly_val <= `SMT_TIME_RST;
         chan_open_out <= 1'b0;
         chan_close_out <= 1'b0;
         meas_start_out <= 1'b0;
         armed_out <= 1'b0;
      end
      else
      begin
         state <= next_state;
         armed_out <= (next_state != ST_IDLE);
         stmr_go <= 1'b0;
         mtmr_go <= 1'b0;
         dly_go <= 1'b0;
         chan_open_out <= (next_state == ST_AOPN);
         chan_close_out <= (next_state == ST_ACLS);
         meas_start_out <= (next_state == ST_AMEA) && (state != ST_AMEA);
         if (state == ST_IDLE)
         begin
            scan_first <= 1'b1;
            scan_done_n <= 17'h00000;
         end
         // leaving scan source: interval restarts
         if (state == ST_SSRC && next_state != ST_SSRC)
         begin
            scan_first <= 1'b0;
            stmr_go <= 1'b1;
         end
         if (state != ST_MOUT && state != ST_MSRC && next_state == ST_MSRC)
         begin
            meas_first <= 1'b1;
            meas_done_n <= 17'h00000;
         end
         if (state == ST_MSRC && next_state != ST_MSRC)
         begin
            meas_first <= 1'b0;
            mtmr_go <= 1'b1;
         end
         // load the shared delay timer
         if (next_state == ST_SDLY && state != ST_SDLY)
         begin
            dly_val <= scan_wait_time;
            dly_go <= 1'b1;
         end
         if (next_state == ST_MDLY && state != ST_MDLY)
         begin
            dly_val <= meas_wait;
            dly_go <= 1'b1;
         end
         if (next_state == ST_ASET && state != ST_ASET)
         begin
            dly_val <= `SMT_SETTLE_MS;
            dly_go <= 1'b1;
         end
         if (state == ST_MOUT)
         begin
            meas_done_n <= meas_done_n + 17'h00001;
            if (next_state == ST_SSRC)
               scan_done_n <= scan_done_n + 17'h00001;
         end
      end
   end

   // pending skip commands, consumed in their source state
   always @(posedge clk_in)
   begin
      if (rst_in || state == ST_IDLE)
      begin
         scan_imm_p <= 1'b0;
         scan_sig_p <= 1'b0;
         meas_imm_p <= 1'b0;
         meas_sig_p <= 1'b0;
      end
      else
      begin
         if (wr_ctrl && wdata_in[`SMT_CTL_SIMM])
            scan_imm_p <= 1'b1;
         else if (state == ST_SSRC)
            scan_imm_p <= 1'b0;
         if (wr_ctrl && wdata_in[`SMT_CTL_SSIG])
            scan_sig_p <= 1'b1;
         else if (state == ST_SSRC)
            scan_sig_p <= 1'b0;
         if (wr_ctrl && wdata_in[`SMT_CTL_MIMM])
            meas_imm_p <= 1'b1;
         else if (state == ST_MSRC)
            meas_imm_p <= 1'b0;
         if (wr_ctrl && wdata_in[`SMT_CTL_MSIG])
            meas_sig_p <= 1'b1;
         else if (state == ST_MSRC)
            meas_sig_p <= 1'b0;
      end
   end

   // trigger-ignored flag, set beats clear
   always @(posedge clk_in)
   begin
      if (rst_in)
         ignored <= 1'b0;
      else if ((ext_trig_in || trig_key_in) && act_src == `SMT_SRC_IMM)
         ignored <= 1'b1;
      else if (wr_in && addr_in == `SMT_REG_STAT && wdata_in[`SMT_STAT_IGN])
         ignored <= 1'b0;
   end

   // output triggers
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pulse_left <= 10'h000;
         pulse_link <= 1'b0;
         done_pulse_out <= 1'b0;
         link_oe_out <= 6'h00;
         link_o_out <= 6'h00;
      end
      else
      begin
         link_o_out <= 6'h00;
         if (state == ST_MOUT)
         begin
            if (meas_src != `SMT_SRC_LINK || !semi_sync || skip_direction_select)
            begin
               pulse_left <= PULSE_CYC[9:0];
               pulse_link <= (meas_src == `SMT_SRC_LINK);
            end
         end
         else if (state == ST_SSRC && scan_done_n != 17'h00000 &&
                  skip_direction_select && pulse_left == 10'h000 &&
                  next_state != ST_SSRC)
         begin
            pulse_left <= PULSE_CYC[9:0];
            pulse_link <= (scan_event_select == `SMT_SRC_LINK);
         end
         else if (pulse_left != 10'h000)
            pulse_left <= pulse_left - 10'h001;
         done_pulse_out <= (pulse_left > 10'h001) && !pulse_link;
         if (semi_sync && meas_src == `SMT_SRC_LINK &&
             (state == ST_AOPN || state == ST_ACLS ||
              state == ST_ASET || state == ST_AMEA))
            link_oe_out <= 6'h01 << link_line;
         else if (pulse_left > 10'h001 && pulse_link)
            link_oe_out <= 6'h01 << link_line;
         else
            link_oe_out <= 6'h00;
      end
   end

   // register read, data one cycle later
   always @(posedge clk_in)
   begin
      if (rst_in || !rd_in)
         rdata_out <= 32'h00000000;
      else
      begin
         case (addr_in)
            `SMT_REG_CFG: rdata_out <= {21'h000000, link_line, semi_sync,
               skip_direction_select, meas_src, scan_event_select};
            `SMT_REG_STMR: rdata_out <= {2'h0, scan_tmr};
            `SMT_REG_SDLY: rdata_out <= {2'h0, scan_wait_time};
            `SMT_REG_MTMR: rdata_out <= {2'h0, meas_tmr};
            `SMT_REG_MDLY: rdata_out <= {2'h0, meas_wait};
            `SMT_REG_SCNT: rdata_out <= {15'h0000, scan_repeat_count};
            `SMT_REG_MCNT: rdata_out <= {15'h0000, meas_cnt};
            `SMT_REG_STAT: rdata_out <= {23'h000000, ignored, 4'h0, state};
            default: rdata_out <= 32'h00000000;
         endcase
      end
   end
endmodule // smtseq_top

// >>> logic/smtseq_defs.vh
// Purpose: constants for the scan/measure trigger sequencer
// Assumes: 50 MHz clock, times held in whole milliseconds
// Notes: register index is the word address on the plain port
`ifndef SMTSEQ_DEFS_VH
`define SMTSEQ_DEFS_VH
// register indices
`define SMT_REG_CTRL 4'h0
`define SMT_REG_CFG 4'h1
`define SMT_REG_STMR 4'h2
`define SMT_REG_SDLY 4'h3
`define SMT_REG_MTMR 4'h4
`define SMT_REG_MDLY 4'h5
`define SMT_REG_SCNT 4'h6
`define SMT_REG_MCNT 4'h7
`define SMT_REG_STAT 4'h8
// control bits, write one to act
`define SMT_CTL_START 0
`define SMT_CTL_SIMM 1
`define SMT_CTL_SSIG 2
`define SMT_CTL_MIMM 3
`define SMT_CTL_MSIG 4
`define SMT_CTL_GRST 5
`define SMT_CTL_PRST 6
`define SMT_CTL_ABORT 7
// config fields and status ignored bit
`define SMT_CFG_SSRC_LSB 0
`define SMT_CFG_MSRC_LSB 3
`define SMT_CFG_FPS 6
`define SMT_CFG_SEMI 7
`define SMT_CFG_LINE_LSB 8
`define SMT_STAT_IGN 8
// event sources
`define SMT_SRC_IMM 3'h0
`define SMT_SRC_TMR 3'h1
`define SMT_SRC_MAN 3'h2
`define SMT_SRC_BUS 3'h3
`define SMT_SRC_EXT 3'h4
`define SMT_SRC_LINK 3'h5
`define SMT_SRC_HOLD 3'h6
// reset values
`define SMT_CFG_RST 11'h000
`define SMT_TIME_RST 30'h00000000
`define SMT_TMR_RST 30'h00000001
`define SMT_CNT_ONE 17'h00001
`define SMT_CNT_INF 17'h00000
// timing
`define SMT_CLK_HZ 50000000
`define SMT_TICK_MS 1
`define SMT_SETTLE_MS 30'h00000003
`define SMT_PULSE_NS 10000
`endif

// >>> logic/smtseq_timer.v
// Purpose: millisecond down counter for delays and intervals
// Assumes: tick_in is a one-cycle pulse each millisecond
// Notes: done_out stays high until the next start
`timescale 1ns/1ps
module smtseq_timer
(
   input wire clk_in,
   input wire rst_in,
   input wire start_in,
   input wire tick_in,
   input wire [29:0] value_in,
   output reg done_out
);
   // remaining milliseconds
   reg [29:0] left;
   // load on start, count on tick
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         left <= 30'h00000000;
         done_out <= 1'b1;
      end
      else if (start_in)
      begin
         left <= value_in;
         done_out <= 1'b0;
      end
      else if (!done_out)
      begin
         // zero left: finished
         if (left == 30'h00000000)
            done_out <= 1'b1;
         else if (tick_in)
            left <= left - 30'h00000001;
      end
   end
endmodule // smtseq_timer

// >>> tb/smtseq_properties.sv
// Purpose: port checker for the trigger sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every instance of the top
`timescale 1ns/1ps
module smtseq_checker
#(
   parameter MS_CYCLES = 10
)
(
   input wire clk_in,
   input wire rst_in,
   input wire rd_in,
   input wire [31:0] rdata_out,
   input wire chan_open_out,
   input wire chan_close_out,
   input wire meas_start_out,
   input wire done_pulse_out,
   input wire [5:0] link_oe_out,
   input wire [5:0] link_o_out,
   input wire armed_out
);
   // cycles since the last close strobe
   reg [15:0] settle_cnt;
   always @(posedge clk_in)
      if (rst_in || chan_close_out) settle_cnt <= 16'h0000;
      else settle_cnt <= settle_cnt + 16'h0001;
   AST_OPEN_CLOSE:
   assert property (@(posedge clk_in) disable iff (rst_in)
      chan_open_out |-> ##[1:4] chan_close_out) else $error("close missing after open");
   AST_NOT_BOTH:
   assert property (@(posedge clk_in) disable iff (rst_in)
      !(chan_open_out && chan_close_out)) else $error("open and close together");
   AST_MEAS_AFTER:
   assert property (@(posedge clk_in) disable iff (rst_in)
      chan_close_out |-> ##[1:1000] meas_start_out) else $error("no measure after close");
   AST_SETTLE:
   assert property (@(posedge clk_in) disable iff (rst_in)
      meas_start_out |-> settle_cnt >= 2 * MS_CYCLES) else $error("settle too short");
   AST_PULSE_LEN:
   assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(done_pulse_out) |=> done_pulse_out [*8]) else $error("done pulse short");
   AST_RD_IDLE:
   assert property (@(posedge clk_in) disable iff (rst_in)
      !$past(rd_in) |-> rdata_out == 32'h00000000) else $error("stray read data");
   AST_OPEN_DRAIN:
   assert property (@(posedge clk_in) disable iff (rst_in)
      link_o_out == 6'h00) else $error("link line driven high");
   AST_ONE_LINE:
   assert property (@(posedge clk_in) disable iff (rst_in)
      $onehot0(link_oe_out)) else $error("several link lines");
   AST_RESET:
   assert property (@(posedge clk_in)
      rst_in |=> !armed_out && !done_pulse_out && link_oe_out == 6'h00)
      else $error("outputs not cleared");
   AST_ARMED:
   assert property (@(posedge clk_in) disable iff (rst_in)
      meas_start_out |-> armed_out) else $error("measure while idle");
endmodule // smtseq_checker
bind smtseq_top smtseq_checker #(.MS_CYCLES(MS_CYCLES)) i_smtseq_checker (
   .clk_in(clk_in), .rst_in(rst_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .chan_open_out(chan_open_out), .chan_close_out(chan_close_out),
   .meas_start_out(meas_start_out), .done_pulse_out(done_pulse_out),
   .link_oe_out(link_oe_out), .link_o_out(link_o_out), .armed_out(armed_out));

// >>> tb/smtseq_meter.sv
// Purpose: model of the measuring engine
// Assumes: start strobe is one cycle long
// Notes: answers a fixed number of cycles later
`timescale 1ns/1ps
module smtseq_meter
#(
   parameter DLY = 4
)
(
   input wire clk_in,
   input wire meas_start_in,
   output reg action_done_out
);
   localparam [7:0] D8 = DLY;
   // cycles left until the answer
   reg [7:0] cnt = 8'h00;
   initial action_done_out = 1'b0;
   // one-cycle done when the count ends
   always @(posedge clk_in)
   begin
      action_done_out <= (cnt == 8'h01);
      if (meas_start_in) cnt <= D8;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
   end
endmodule // smtseq_meter

// >>> tb/smtseq_bench.sv
// Purpose: self-checking bench of the sequencer
// Assumes: 10 cycles per millisecond
// Notes: one task per scenario
`timescale 1ns/1ps
module smtseq_bench;
   reg clk_in, rst_in, wr_in, rd_in, remote_in;
   reg bus_trig_in, ext_trig_in, link_trig_in, trig_key_in;
   reg [3:0] addr_in;
   reg [31:0] wdata_in;
   wire [31:0] rdata_out;
   wire action_done_in, chan_open_out, chan_close_out, meas_start_out;
   wire done_pulse_out, armed_out;
   wire [5:0] link_oe_out, link_o_out;
   integer mismatches, check_count, n_meas, n_link, base, nl;
   smtseq_top #(.MS_CYCLES(10)) i_smtseq_top (.clk_in(clk_in), .rst_in(rst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .bus_trig_in(bus_trig_in), .ext_trig_in(ext_trig_in),
      .link_trig_in(link_trig_in), .trig_key_in(trig_key_in), .remote_in(remote_in),
      .action_done_in(action_done_in), .chan_open_out(chan_open_out),
      .chan_close_out(chan_close_out), .meas_start_out(meas_start_out),
      .done_pulse_out(done_pulse_out), .link_oe_out(link_oe_out),
      .link_o_out(link_o_out), .armed_out(armed_out));
   smtseq_meter #(.DLY(4)) i_smtseq_meter (.clk_in(clk_in),
      .meas_start_in(meas_start_out), .action_done_out(action_done_in));
   // clock of 20 ns
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // event counters
   always @(posedge meas_start_out) n_meas = n_meas + 1;
   always @(posedge (|link_oe_out)) n_link = n_link + 1;
   task chk(input [31:0] got, input [31:0] exp);
   begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task wr(input [3:0] a, input [31:0] d);
   begin
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   end
   endtask
   task rd(input [3:0] a, input [31:0] e);
   begin
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
   end
   endtask
   // one-cycle pulse on {key, link, ext, bus}
   task pulse(input [3:0] m);
   begin
      @(posedge clk_in);
      {trig_key_in, link_trig_in, ext_trig_in, bus_trig_in} <= m;
      @(posedge clk_in);
      {trig_key_in, link_trig_in, ext_trig_in, bus_trig_in} <= 4'h0;
   end
   endtask
   // wait until the sequencer is idle, bounded
   task idle;
      integer i;
   begin
      repeat (3) @(posedge clk_in);
      i = 0;
      while (armed_out !== 1'b0 && i < 3000)
      begin
         @(posedge clk_in);
         i = i + 1;
      end
      if (i == 3000) chk(32'h0, 32'h1);
      #1;
   end
   endtask
   task t_regs;
   begin
      rd(4'h1, 32'h0);
      rd(4'h2, 32'h1);
      rd(4'h5, 32'h0);
      rd(4'h6, 32'h1);
      rd(4'h7, 32'h1);
      rd(4'hF, 32'h0);
      wr(4'h3, 32'h7);
      wr(4'h1, 32'h12);
      wr(4'h0, 32'h40);
      rd(4'h6, 32'h0);
      rd(4'h1, 32'h0);
      rd(4'h3, 32'h0);
      rd(4'h7, 32'h1);
      wr(4'h0, 32'h20);
      rd(4'h6, 32'h1);
   end
   endtask
   task t_ign;
   begin
      rd(4'h8, 32'h0);
      pulse(4'h2);
      rd(4'h8, 32'h100);
      wr(4'h8, 32'h100);
      rd(4'h8, 32'h0);
   end
   endtask
   task t_imm;
   begin
      wr(4'h7, 32'h2);
      base = n_meas;
      wr(4'h0, 32'h1);
      idle;
      chk(n_meas - base, 2);
      chk(done_pulse_out, 1);
      wr(4'h7, 32'h1);
   end
   endtask
   task t_hold;
   begin
      wr(4'h1, 32'h36);
      base = n_meas;
      wr(4'h0, 32'h1);
      pulse(4'hF);
      repeat (60) @(posedge clk_in);
      chk(n_meas - base, 0);
      chk(armed_out, 1);
      wr(4'h0, 32'h4);
      repeat (60) @(posedge clk_in);
      chk(n_meas - base, 0);
      wr(4'h0, 32'h8);
      idle;
      chk(n_meas - base, 1);
   end
   endtask
   task t_man;
   begin
      wr(4'h1, 32'h2);
      remote_in <= 1'b1;
      base = n_meas;
      wr(4'h0, 32'h1);
      pulse(4'h8);
      repeat (60) @(posedge clk_in);
      chk(n_meas - base, 0);
      remote_in <= 1'b0;
      pulse(4'h8);
      idle;
      chk(n_meas - base, 1);
   end
   endtask
   task t_dly;
   begin
      wr(4'h3, 32'h5);
      wr(4'h1, 32'h22C);
      base = n_meas;
      nl = n_link;
      wr(4'h0, 32'h1);
      repeat (10) @(posedge clk_in);
      pulse(4'h2);
      repeat (30) @(posedge clk_in);
      rd(4'h8, 32'h2);
      pulse(4'h4);
      repeat (40) @(posedge clk_in);
      chk(n_meas - base, 0);
      pulse(4'h4);
      idle;
      chk(n_meas - base, 1);
      chk(n_link - nl, 1);
      wr(4'h3, 32'h0);
   end
   endtask
   task t_fps;
   begin
      wr(4'h1, 32'h64);
      base = n_meas;
      wr(4'h0, 32'h1);
      idle;
      chk(n_meas - base, 1);
      wr(4'h1, 32'hA8);
      nl = n_link;
      wr(4'h0, 32'h1);
      repeat (10) @(posedge clk_in);
      pulse(4'h4);
      idle;
      chk(n_link - nl, 1);
      chk(link_oe_out, 0);
   end
   endtask
   // second scan waits its event, return pulse on leaving
   task t_ret;
   begin
      wr(4'h6, 32'h2);
      wr(4'h1, 32'h44);
      base = n_meas;
      wr(4'h0, 32'h1);
      repeat (700) @(posedge clk_in);
      chk(n_meas - base, 1);
      pulse(4'h2);
      repeat (3) @(posedge clk_in);
      #1 chk(done_pulse_out, 1);
      idle;
      chk(n_meas - base, 2);
      wr(4'h6, 32'h1);
   end
   endtask
   task conclude;
   begin
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   // watchdog against a hang
   initial
   begin
      #1000000;
      chk(32'h0, 32'h1);
      conclude;
   end
   initial
   begin
      {rst_in, wr_in, rd_in, remote_in} = 4'h8;
      {bus_trig_in, ext_trig_in, link_trig_in, trig_key_in} = 4'h0;
      addr_in = 4'h0;
      wdata_in = 32'h0;
      {mismatches, check_count, n_meas, n_link} = 128'h0;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      t_regs;
      t_ign;
      t_imm;
      t_hold;
      t_man;
      t_dly;
      t_fps;
      t_ret;
      conclude;
   end
endmodule // smtseq_bench
